// ===== rtl/typec_attach_defines.svh
// constants for the type-c attach and phy enable decoder
`ifndef TYPEC_ATTACH_DEFINES_SVH
`define TYPEC_ATTACH_DEFINES_SVH

// number of ports with a presence input
`define TPAS_NUM_PORTS 3
// index of the port that has orientation and scheme two inputs
`define TPAS_TYPEC_PORT 1
// synchroniser depth in flip-flops
`define TPAS_SYNC_STAGES 2
// cycles from an input edge to the phy enable outputs
`define TPAS_LATENCY 3
// value of every phy enable while in reset
`define TPAS_EN_RESET 1'h0

`endif

// ===== rtl/typec_attach_pkg.sv
// types shared by the type-c attach decoder
package typec_attach_pkg;

  // signalling scheme chosen by the scheme-select input
  typedef enum logic {
    SCHEME_ONE,
    SCHEME_TWO
  } scheme_e;

endpackage

// ===== rtl/sync_2ff.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/10ps
`include "typec_attach_defines.svh"

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;

  // first stage feeds only the second; bits are not coherent as a word
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= '0;
      stable <= '0;
    end else begin
      meta <= async_i;
      stable <= meta;
    end
  end

  assign sync_o = stable;

endmodule

// ===== rtl/typec_phy_attach_select.sv
// type-c attach and orientation decoder driving per-port phy enables
`timescale 1ns/10ps
`include "typec_attach_defines.svh"

module typec_phy_attach_select #(
  parameter int NUM_PORTS = `TPAS_NUM_PORTS,
  parameter int TYPEC_PORT = `TPAS_TYPEC_PORT
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [NUM_PORTS-1:0] attach_present_i,
  input wire logic plug_flip_in_i,
  input wire logic alt_present_orient_a_i,
  input wire logic alt_present_orient_b_i,
  input wire logic present_polarity_sel_i,
  input wire logic ctl_scheme_sel_i,
  output logic [NUM_PORTS-1:0] phy_a_en_o,
  output logic [NUM_PORTS-1:0] phy_b_en_o,
  output typec_attach_pkg::scheme_e scheme_o
);

  import typec_attach_pkg::*;

  localparam int SYNC_W = NUM_PORTS + 5;
  // a port without orientation, used by the checks below
  localparam int OTHER_PORT = (TYPEC_PORT == 0) ? 1 : 0;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] synced;
  logic [NUM_PORTS-1:0] s_present;
  logic s_flip;
  logic s_alt_a;
  logic s_alt_b;
  logic s_pol;
  logic s_scheme;

  // gather every pin so one synchroniser bank covers them all
  assign raw_in = {ctl_scheme_sel_i, present_polarity_sel_i,
                   alt_present_orient_b_i, alt_present_orient_a_i,
                   plug_flip_in_i, attach_present_i};

  sync_2ff #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i(raw_in),
    .sync_o(synced)
  );

  // split the synchronised word back into named levels
  assign s_present = synced[NUM_PORTS-1:0];
  assign s_flip = synced[NUM_PORTS];
  assign s_alt_a = synced[NUM_PORTS+1];
  assign s_alt_b = synced[NUM_PORTS+2];
  assign s_pol = synced[NUM_PORTS+3];
  assign s_scheme = synced[NUM_PORTS+4];

  logic [NUM_PORTS-1:0] present_act;
  logic flip_act;
  logic alt_a_act;
  logic alt_b_act;
  logic scheme_two;

  // one polarity bit sets every presence and orientation level; scheme select is not inverted
  // xor with polarity: low keeps high-true, high makes low-true
  assign present_act = s_present ^ {NUM_PORTS{s_pol}};
  // flip_act high means phy b; inversion by polarity
  assign flip_act = s_flip ^ s_pol;
  assign alt_a_act = s_alt_a ^ s_pol;
  assign alt_b_act = s_alt_b ^ s_pol;
  assign scheme_two = s_scheme;

  logic mode1_a;
  logic mode1_b;
  logic [NUM_PORTS-1:0] next_phy_a;
  logic [NUM_PORTS-1:0] next_phy_b;
  scheme_e next_scheme;

  // orientation only matters while the port is attached
  assign mode1_a = present_act[TYPEC_PORT] & ~flip_act;
  assign mode1_b = present_act[TYPEC_PORT] & flip_act;
  assign next_scheme = scheme_two ? SCHEME_TWO : SCHEME_ONE;

  // per-port enable selection
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    if (p == TYPEC_PORT) begin : g_typec
      // scheme two replaces presence and orientation
      assign next_phy_a[p] = scheme_two ? alt_a_act : mode1_a;
      assign next_phy_b[p] = scheme_two ? alt_b_act : mode1_b;
    end else begin : g_plain
      // attached turns the single phy on, detached saves power
      assign next_phy_a[p] = present_act[p];
      // no orientation on this port, so its b phy is never used
      assign next_phy_b[p] = 1'h0;
    end
  end

  // registered enables keep decode glitches off the phy controls
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_a_en_o <= {NUM_PORTS{`TPAS_EN_RESET}};
      phy_b_en_o <= {NUM_PORTS{`TPAS_EN_RESET}};
      scheme_o <= SCHEME_ONE;
    end else begin
      phy_a_en_o <= next_phy_a;
      phy_b_en_o <= next_phy_b;
      scheme_o <= next_scheme;
    end
  end

  // checks: every input seen at an edge reaches the outputs three edges on

  // attach at high-true polarity enables the phy
  plain_attach_on_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (!present_polarity_sel_i && attach_present_i[OTHER_PORT])
      |-> ##3 phy_a_en_o[OTHER_PORT])
    else $error("plain port phy not enabled on attach");

  // inverted polarity turns a high presence into detach
  plain_inverted_off_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (present_polarity_sel_i && attach_present_i[OTHER_PORT])
      |-> ##3 !phy_a_en_o[OTHER_PORT])
    else $error("inverted polarity presence left phy on");

  // enable rises only three edges after an attach was seen
  rise_has_cause_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    $rose(phy_a_en_o[OTHER_PORT])
      |-> ($past(attach_present_i[OTHER_PORT], 3)
           ^ $past(present_polarity_sel_i, 3)))
    else $error("phy enable rose without a synchronised attach");

  // orientation high with high-true polarity picks phy b
  flip_picks_b_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (!ctl_scheme_sel_i && !present_polarity_sel_i
      && attach_present_i[TYPEC_PORT] && plug_flip_in_i)
      |-> ##3 (phy_b_en_o[TYPEC_PORT] && !phy_a_en_o[TYPEC_PORT]))
    else $error("orientation one did not select phy b");

  // orientation high with low-true polarity picks phy a
  flip_inv_a_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (!ctl_scheme_sel_i && present_polarity_sel_i
      && !attach_present_i[TYPEC_PORT] && plug_flip_in_i)
      |-> ##3 (phy_a_en_o[TYPEC_PORT] && !phy_b_en_o[TYPEC_PORT]))
    else $error("inverted orientation one did not select phy a");

  // in scheme one, no phy of the type-c port runs while it is detached
  detached_both_off_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (!ctl_scheme_sel_i
      && (attach_present_i[TYPEC_PORT] == present_polarity_sel_i))
      |-> ##3 !(phy_a_en_o[TYPEC_PORT] || phy_b_en_o[TYPEC_PORT]))
    else $error("detached type-c port has a phy enabled");

  // scheme one never enables both orientations together
  one_phy_only_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    !ctl_scheme_sel_i
      |-> ##3 !(phy_a_en_o[TYPEC_PORT] && phy_b_en_o[TYPEC_PORT]))
    else $error("both orientation phys enabled in scheme one");

  // asserted orientation-a presence enables phy a
  alt_a_enables_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctl_scheme_sel_i && !present_polarity_sel_i && alt_present_orient_a_i)
      |-> ##3 phy_a_en_o[TYPEC_PORT])
    else $error("orientation-a presence did not enable phy a");

  // low-true polarity turns a high orientation-a input into off
  alt_a_inverted_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctl_scheme_sel_i && present_polarity_sel_i && alt_present_orient_a_i)
      |-> ##3 !phy_a_en_o[TYPEC_PORT])
    else $error("inverted orientation-a presence left phy a on");

  // phy b follows orientation-b presence under the polarity
  alt_b_follows_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    ctl_scheme_sel_i
      |-> ##3 (phy_b_en_o[TYPEC_PORT]
               == ($past(alt_present_orient_b_i, 3)
                   ^ $past(present_polarity_sel_i, 3))))
    else $error("phy b does not follow orientation-b presence");

  // scheme two ignores the orientation input entirely
  scheme_two_ignores_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    (ctl_scheme_sel_i && !present_polarity_sel_i
      && alt_present_orient_a_i && !alt_present_orient_b_i)
      |-> ##3 (phy_a_en_o[TYPEC_PORT] && !phy_b_en_o[TYPEC_PORT]))
    else $error("scheme two decode disturbed by scheme one inputs");

  // reported scheme tracks the select input
  scheme_report_a: assert property (
    @(posedge clock_i) disable iff (!arst_n_i)
    1'h1 |-> ##3
      (scheme_o == ($past(ctl_scheme_sel_i, 3) ? SCHEME_TWO : SCHEME_ONE)))
    else $error("scheme output does not track scheme select");

  // main scenarios
  flipped_attach_c: cover property (
    @(posedge clock_i) disable iff (!arst_n_i)
    scheme_o == SCHEME_ONE && phy_b_en_o[TYPEC_PORT]);

  scheme_two_both_c: cover property (
    @(posedge clock_i) disable iff (!arst_n_i)
    scheme_o == SCHEME_TWO && phy_a_en_o[TYPEC_PORT]
      && phy_b_en_o[TYPEC_PORT]);

  inverted_attach_c: cover property (
    @(posedge clock_i) disable iff (!arst_n_i)
    present_polarity_sel_i && !attach_present_i[OTHER_PORT]
      ##3 phy_a_en_o[OTHER_PORT]);

endmodule

// ===== test/attach_ctl_model.sv
// connector controller model driving attach levels into the decoder
`timescale 1ns/10ps

module attach_ctl_model #(
  parameter int NUM_PORTS = 3
) (
  input wire logic clock_i,
  output logic [NUM_PORTS-1:0] present_o,
  output logic flip_o,
  output logic alt_a_o,
  output logic alt_b_o,
  output logic pol_o,
  output logic scheme_sel_o
);
  // straps and pull-downs leave every level low at power-up
  initial begin
    {scheme_sel_o, pol_o, alt_b_o, alt_a_o, flip_o, present_o} = '0;
  end

  // levels move only on the falling edge, clear of the sampling edge
  // apply the whole level vector, scheme select in the top bit
  task automatic apply(input logic [NUM_PORTS+4:0] v);
    @(negedge clock_i);
    {scheme_sel_o, pol_o, alt_b_o, alt_a_o, flip_o, present_o} = v;
  endtask
endmodule

// ===== test/typec_phy_attach_select_test.sv
// self-checking bench for the type-c attach decoder
`timescale 1ns/10ps
`include "typec_attach_defines.svh"

module typec_phy_attach_select_test;
  import typec_attach_pkg::*;
  localparam int NP = `TPAS_NUM_PORTS;
  localparam int TP = `TPAS_TYPEC_PORT;
  localparam logic [7:0] TMASK = 8'h12;
  logic clock_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [NP-1:0] present, phy_a, phy_b;
  logic flip, alt_a, alt_b, pol, sel;
  scheme_e scheme;
  logic [7:0] e;
  logic [7:0] got;
  int bad_count = 0;
  int check_count = 0;

  // free-running core clock, 8 ns period
  initial begin
    forever #4 clock_i = ~clock_i;
  end

  attach_ctl_model #(.NUM_PORTS(NP)) partner (.clock_i(clock_i),
    .present_o(present), .flip_o(flip), .alt_a_o(alt_a),
    .alt_b_o(alt_b), .pol_o(pol), .scheme_sel_o(sel));

  typec_phy_attach_select DUT (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .attach_present_i(present), .plug_flip_in_i(flip),
    .alt_present_orient_a_i(alt_a), .alt_present_orient_b_i(alt_b),
    .present_polarity_sel_i(pol), .ctl_scheme_sel_i(sel),
    .phy_a_en_o(phy_a), .phy_b_en_o(phy_b), .scheme_o(scheme));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // v = {sel, pol, alt_b, alt_a, flip, present[2:0]}, result {b, a}
  function automatic logic [5:0] expect_en(input logic [7:0] v);
    logic [NP-1:0] act, a, b;
    act = v[NP-1:0] ^ {NP{v[6]}};
    a = act;
    b = '0;
    if (v[7]) begin
      a[TP] = v[4] ^ v[6];
      b[TP] = v[5] ^ v[6];
    end else begin
      b[TP] = act[TP] & (v[3] ^ v[6]);
      a[TP] = act[TP] & ~(v[3] ^ v[6]);
    end
    return {b, a};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard: the sequence needs about 800 cycles
  initial begin
    repeat (4000) @(posedge clock_i);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    check({2'h0, phy_b, phy_a}, 8'h00);
    check({7'h00, scheme}, {7'h00, SCHEME_ONE});
    arst_n_i = 1'h1;
    // exact three-edge latency on a single presence bit
    partner.apply(8'h01);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check({2'h0, phy_b, phy_a}, 8'h00);
    @(negedge clock_i);
    check({2'h0, phy_b, phy_a}, 8'h01);
    // legacy board: presence tied high keeps every phy a on
    partner.apply(8'h07);
    repeat (3) @(posedge clock_i);
    #1;
    check({2'h0, phy_b, phy_a}, 8'h07);
    // every combination of levels, polarity and scheme
    for (int i = 0; i < 256; i++) begin
      partner.apply(i[7:0]);
      repeat (3) @(posedge clock_i);
      #1;
      e = {2'h0, expect_en(i[7:0])};
      got = {2'h0, phy_b, phy_a};
      check(got & ~TMASK, e & ~TMASK);
      check(got & TMASK, e & TMASK);
      check({7'h00, scheme}, {7'h00, scheme_e'(i[7])});
    end
    // reset in mid-run clears the enables and the scheme at once
    @(negedge clock_i);
    arst_n_i = 1'h0;
    #1;
    check({2'h0, phy_b, phy_a}, 8'h00);
    check({7'h00, scheme}, {7'h00, SCHEME_ONE});
    @(negedge clock_i);
    arst_n_i = 1'h1;
    // second release: same three-edge latency from a cleared pipeline
    partner.apply(8'h05);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check({2'h0, phy_b, phy_a}, 8'h00);
    @(negedge clock_i);
    check({2'h0, phy_b, phy_a}, 8'h05);
    summarize();
  end
endmodule
